// >>> logic/cra_pkg.sv
// Package of constants and types for the cable reflection amplitude register bank
package cra_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int BE_W     = 4;
  localparam int REG_W    = 16;
  localparam int AMP_W    = 7;
  localparam int IDX_W    = 10;
  localparam int NUM_REGS = 6;
  localparam int SEL_W    = 3;
  localparam int CNT_W    = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_AMP_A12  = 10'h19a;
  localparam logic [IDX_W-1:0] IDX_AMP_A34  = 10'h19b;
  localparam logic [IDX_W-1:0] IDX_AMP_A5B1 = 10'h19c;
  localparam logic [IDX_W-1:0] IDX_AMP_B23  = 10'h19d;
  localparam logic [IDX_W-1:0] IDX_AMP_B45  = 10'h19e;
  localparam logic [IDX_W-1:0] IDX_AMP_C12  = 10'h19f;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 10'h1b0;
  localparam logic [IDX_W-1:0] IDX_STAT     = 10'h1b1;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int AMP_LO_LSB      = 0;
  localparam int AMP_HI_LSB      = 8;
  localparam int CTRL_FREEZE_BIT = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam int STAT_VALID_BIT  = 0;
  localparam int STAT_FROZEN_BIT = 1;
  localparam int STAT_DROP_BIT   = 2;
  localparam int STAT_CNT_LSB    = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [AMP_W-1:0]  AMP_RST   = 7'h00;
  localparam logic [CNT_W-1:0]  CNT_RST   = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [AMP_W-1:0] hi;
    logic [AMP_W-1:0] lo;
  } cra_pair_t;

  typedef cra_pair_t [NUM_REGS-1:0] cra_bank_t;

  typedef struct packed {
    logic             amp_hit;
    logic [SEL_W-1:0] amp_sel;
    logic             ctrl_hit;
    logic             stat_hit;
  } cra_dec_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK  = 1'b1
  } cra_bus_st_t;

endpackage : cra_pkg

// >>> logic/cra_pair_reg.sv
// One read-only amplitude register holding two peak strengths
`timescale 1ns/10ps
module cra_pair_reg
  import cra_pkg::*;
(
  input  wire logic             clk_sys,  // System clock
  input  wire logic             sys_rst,  // Synchronous reset
  input  wire logic             load_en,  // Capture new measurement
  input  wire logic             clear_en, // Return fields to zero
  input  wire cra_pair_t        pair_in,  // Measured strengths
  output      logic [REG_W-1:0] value     // Register image
);

  cra_pair_t pair_r;
  cra_pair_t pair_nxt;

  // ----------------------------------------------------------------
  // Next value: a fresh measurement wins over a clear
  // ----------------------------------------------------------------
  always_comb
  begin
    pair_nxt = pair_r;
    if (load_en)
    begin
      pair_nxt = pair_in;
    end
    else if (clear_en)
    begin
      pair_nxt = '{hi: AMP_RST, lo: AMP_RST};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pair_r <= '{hi: AMP_RST, lo: AMP_RST};
    end
    else
    begin
      pair_r <= pair_nxt;
    end
  end

  // Bits 15 and 7 are tied low
  always_comb
  begin
    value = '0;
    value[AMP_LO_LSB +: AMP_W] = pair_r.lo;
    value[AMP_HI_LSB +: AMP_W] = pair_r.hi;
  end

endmodule : cra_pair_reg

// >>> logic/cra_addr_dec.sv
// Address decoder for the amplitude register bank
`timescale 1ns/10ps
module cra_addr_dec
  import cra_pkg::*;
(
  input  wire logic [ADDR_W-1:0] address, // Avalon byte address
  output      cra_dec_t          dec      // Decoded target
);

  logic [IDX_W-1:0] idx;

  assign idx = address[ADDR_W-1:2];

  always_comb
  begin
    dec = '0;
    if (address[1:0] != 2'h0)
    begin
      dec = '0;
    end
    else if (idx == IDX_AMP_A12)
    begin
      dec.amp_hit = 1'b1;
      dec.amp_sel = 3'h0;
    end
    else if (idx == IDX_AMP_A34)
    begin
      dec.amp_hit = 1'b1;
      dec.amp_sel = 3'h1;
    end
    else if (idx == IDX_AMP_A5B1)
    begin
      dec.amp_hit = 1'b1;
      dec.amp_sel = 3'h2;
    end
    else if (idx == IDX_AMP_B23)
    begin
      dec.amp_hit = 1'b1;
      dec.amp_sel = 3'h3;
    end
    else if (idx == IDX_AMP_B45)
    begin
      dec.amp_hit = 1'b1;
      dec.amp_sel = 3'h4;
    end
    else if (idx == IDX_AMP_C12)
    begin
      dec.amp_hit = 1'b1;
      dec.amp_sel = 3'h5;
    end
    else if (idx == IDX_CTRL)
    begin
      dec.ctrl_hit = 1'b1;
    end
    else if (idx == IDX_STAT)
    begin
      dec.stat_hit = 1'b1;
    end
  end

endmodule : cra_addr_dec

// >>> logic/cra_regs_top.sv
// Cable reflection amplitude register bank with Avalon-MM slave
//
// Function
// - reg 0x019A: A peak1 low, A peak2 high
// - reg 0x019B: A peak3 low, A peak4 high
// - reg 0x019C: A peak5 low, B peak1 high
// - reg 0x019D: B peak2 low, B peak3 high
// - reg 0x019E: B peak4 low, B peak5 high
// - reg 0x019F: C peak1 low, C peak2 high
// - fields hold strength, read-only, zero after reset
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module cra_regs_top
  import cra_pkg::*;
(
  input  wire logic              clk_sys,               // System clock, 100 MHz
  input  wire logic              sys_rst,               // Synchronous reset, active high
  input  wire logic [ADDR_W-1:0] avs_address,           // Byte address
  input  wire logic              avs_read,              // Read request
  input  wire logic              avs_write,             // Write request
  input  wire logic [DATA_W-1:0] avs_writedata,         // Write data
  input  wire logic [BE_W-1:0]   avs_byteenable,        // Byte lanes
  output      logic [DATA_W-1:0] avs_readdata,          // Read data
  output      logic              avs_waitrequest,       // Stall
  input  wire logic [AMP_W-1:0]  chan_a_peak1_strength, // Channel A peak 1
  input  wire logic [AMP_W-1:0]  chan_a_peak2_strength, // Channel A peak 2
  input  wire logic [AMP_W-1:0]  chan_a_peak3_strength, // Channel A peak 3
  input  wire logic [AMP_W-1:0]  chan_a_peak4_strength, // Channel A peak 4
  input  wire logic [AMP_W-1:0]  chan_a_peak5_strength, // Channel A peak 5
  input  wire logic [AMP_W-1:0]  chan_b_peak1_strength, // Channel B peak 1
  input  wire logic [AMP_W-1:0]  chan_b_peak2_strength, // Channel B peak 2
  input  wire logic [AMP_W-1:0]  chan_b_peak3_strength, // Channel B peak 3
  input  wire logic [AMP_W-1:0]  chan_b_peak4_strength, // Channel B peak 4
  input  wire logic [AMP_W-1:0]  chan_b_peak5_strength, // Channel B peak 5
  input  wire logic [AMP_W-1:0]  chan_c_peak1_strength, // Channel C peak 1
  input  wire logic [AMP_W-1:0]  chan_c_peak2_strength, // Channel C peak 2
  input  wire logic              meas_done              // One-cycle result strobe
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cra_bank_t        meas_bank;
  logic [AMP_W-1:0] peak_in [2*NUM_REGS];
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] stat_word;
  logic             acc_req;
  logic [REG_W-1:0] amp_val [NUM_REGS];
  cra_dec_t         dec;
  logic [DATA_W-1:0] rd_word;
  logic             load_en;
  logic             wr_ctrl;

  cra_bus_st_t       st_r;
  cra_bus_st_t       st_nxt;
  logic              waitreq_r;
  logic              waitreq_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  logic              freeze_r;
  logic              freeze_nxt;
  logic              clr_r;
  logic              clr_nxt;

  logic              valid_r;
  logic              valid_nxt;
  logic              drop_r;
  logic              drop_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;

  // ----------------------------------------------------------------
  // Measured strengths in register order, low field first
  // ----------------------------------------------------------------
  assign peak_in[0]  = chan_a_peak1_strength;
  assign peak_in[1]  = chan_a_peak2_strength;
  assign peak_in[2]  = chan_a_peak3_strength;
  assign peak_in[3]  = chan_a_peak4_strength;
  assign peak_in[4]  = chan_a_peak5_strength;
  assign peak_in[5]  = chan_b_peak1_strength;
  assign peak_in[6]  = chan_b_peak2_strength;
  assign peak_in[7]  = chan_b_peak3_strength;
  assign peak_in[8]  = chan_b_peak4_strength;
  assign peak_in[9]  = chan_b_peak5_strength;
  assign peak_in[10] = chan_c_peak1_strength;
  assign peak_in[11] = chan_c_peak2_strength;

  // Results are taken only while software has not frozen the bank
  assign load_en = meas_done && !freeze_r;

  // ----------------------------------------------------------------
  // Amplitude registers
  // ----------------------------------------------------------------
  generate
    for (genvar g = 0; g < NUM_REGS; g++)
    begin : g_pair
      // One register per pair of peaks, even entry in the low field
      assign meas_bank[g] = '{hi: peak_in[2*g+1], lo: peak_in[2*g]};

      cra_pair_reg u_pair (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .load_en  (load_en),
        .clear_en (clr_r),
        .pair_in  (meas_bank[g]),
        .value    (amp_val[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  cra_addr_dec u_dec (
    .address (avs_address),
    .dec     (dec)
  );

  // ----------------------------------------------------------------
  // Control and status words as software reads them
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_word                  = '0;
    ctrl_word[CTRL_FREEZE_BIT] = freeze_r;
  end

  always_comb
  begin
    stat_word                        = '0;
    stat_word[STAT_VALID_BIT]        = valid_r;
    stat_word[STAT_FROZEN_BIT]       = freeze_r;
    stat_word[STAT_DROP_BIT]         = drop_r;
    stat_word[STAT_CNT_LSB +: CNT_W] = cnt_r;
  end

  // Unmapped and misaligned addresses read zero
  always_comb
  begin
    rd_word = '0;
    if (dec.amp_hit)
    begin
      rd_word[REG_W-1:0] = amp_val[dec.amp_sel];
    end
    else if (dec.ctrl_hit)
    begin
      rd_word = ctrl_word;
    end
    else if (dec.stat_hit)
    begin
      rd_word = stat_word;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake: every access ends one cycle after it is seen
  // ----------------------------------------------------------------
  // Read and write are never high together; either one opens an access
  assign acc_req = avs_read || avs_write;

  always_comb
  begin
    st_nxt      = st_r;
    waitreq_nxt = 1'b1;
    rdata_nxt   = rdata_r;
    wr_ctrl     = 1'b0;
    case (st_r)
      ST_IDLE:
      begin
        // Read data is latched at the taking edge and stands through the answer
        if (acc_req)
        begin
          st_nxt      = ST_ACK;
          waitreq_nxt = 1'b0;
          rdata_nxt   = avs_read ? rd_word : RDATA_RST;
        end
      end
      ST_ACK:
      begin
        st_nxt = ST_IDLE;
        // Only the control word accepts data; amplitude writes fall away
        wr_ctrl = avs_write && dec.ctrl_hit && avs_byteenable[0];
      end
      default:
      begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_r      <= ST_IDLE;
      waitreq_r <= 1'b1;
      rdata_r   <= RDATA_RST;
    end
    else
    begin
      st_r      <= st_nxt;
      waitreq_r <= waitreq_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = waitreq_r;

  // ----------------------------------------------------------------
  // Control: freeze level and self-clearing clear pulse
  // ----------------------------------------------------------------
  always_comb
  begin
    freeze_nxt = freeze_r;
    clr_nxt    = 1'b0;
    if (wr_ctrl)
    begin
      freeze_nxt = avs_writedata[CTRL_FREEZE_BIT];
      clr_nxt    = avs_writedata[CTRL_CLEAR_BIT];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      freeze_r <= 1'b0;
      clr_r    <= 1'b0;
    end
    else
    begin
      freeze_r <= freeze_nxt;
      clr_r    <= clr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Status: a capture in the clear cycle survives the clear
  // ----------------------------------------------------------------
  always_comb
  begin
    valid_nxt = valid_r;
    drop_nxt  = drop_r;
    if (clr_r)
    begin
      valid_nxt = 1'b0;
      drop_nxt  = 1'b0;
    end
    if (load_en)
    begin
      valid_nxt = 1'b1;
    end
    if (meas_done && freeze_r)
    begin
      drop_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      valid_r <= 1'b0;
      drop_r  <= 1'b0;
    end
    else
    begin
      valid_r <= valid_nxt;
      drop_r  <= drop_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Capture count: restarts at one when a capture meets a clear
  // ----------------------------------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load_en)
    begin
      cnt_nxt = clr_r ? 8'h01 : cnt_r + 8'h01;
    end
    else if (clr_r)
    begin
      cnt_nxt = CNT_RST;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cnt_r <= CNT_RST;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : cra_regs_top

// >>> sim/cra_regs_monitor.sv
// Checker for the amplitude register bank bus and data map
`timescale 1ns/10ps
module cra_regs_monitor
  import cra_pkg::*;
(
  input wire logic              clk_sys,               // Clock
  input wire logic              sys_rst,               // Reset
  input wire logic [ADDR_W-1:0] avs_address,           // Address
  input wire logic              avs_read,              // Read
  input wire logic              avs_write,             // Write
  input wire logic [DATA_W-1:0] avs_writedata,         // Write data
  input wire logic [BE_W-1:0]   avs_byteenable,        // Lanes
  input wire logic [DATA_W-1:0] avs_readdata,          // Read data
  input wire logic              avs_waitrequest,       // Stall
  input wire logic [AMP_W-1:0]  chan_a_peak1_strength, // A1
  input wire logic [AMP_W-1:0]  chan_a_peak2_strength, // A2
  input wire logic [AMP_W-1:0]  chan_a_peak3_strength, // A3
  input wire logic [AMP_W-1:0]  chan_a_peak4_strength, // A4
  input wire logic [AMP_W-1:0]  chan_a_peak5_strength, // A5
  input wire logic [AMP_W-1:0]  chan_b_peak1_strength, // B1
  input wire logic [AMP_W-1:0]  chan_b_peak2_strength, // B2
  input wire logic [AMP_W-1:0]  chan_b_peak3_strength, // B3
  input wire logic [AMP_W-1:0]  chan_b_peak4_strength, // B4
  input wire logic [AMP_W-1:0]  chan_b_peak5_strength, // B5
  input wire logic [AMP_W-1:0]  chan_c_peak1_strength, // C1
  input wire logic [AMP_W-1:0]  chan_c_peak2_strength, // C2
  input wire logic              meas_done              // Strobe
);
  // ----------------------------------------------------------------
  // Shadow of the stored strengths
  // ----------------------------------------------------------------
  logic [15:0] sh_r [2:7];
  logic [15:0] exp_r;
  logic        frz_r;
  logic        clr_r;
  wire  [83:0] s = {chan_c_peak2_strength, chan_c_peak1_strength, chan_b_peak5_strength,
    chan_b_peak4_strength, chan_b_peak3_strength, chan_b_peak2_strength, chan_b_peak1_strength,
    chan_a_peak5_strength, chan_a_peak4_strength, chan_a_peak3_strength, chan_a_peak2_strength,
    chan_a_peak1_strength};
  wire amp = avs_address[11:5] == 7'h33 && avs_address[4:2] > 3'h1 && avs_address[1:0] == 2'h0;
  wire ctl_wr = avs_write && !avs_waitrequest && avs_address == 12'h6c0 && avs_byteenable[0];

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      frz_r <= 1'b0;
      clr_r <= 1'b0;
      exp_r <= 16'h0000;
      for (int k = 2; k < 8; k++)
        sh_r[k] <= 16'h0000;
    end
    else
    begin
      if (ctl_wr)
        frz_r <= avs_writedata[0];
      clr_r <= ctl_wr && avs_writedata[1];
      if (avs_read && avs_waitrequest && amp)
        exp_r <= sh_r[avs_address[4:2]];
      for (int k = 2; k < 8; k++)
        if (meas_done && !frz_r)
          sh_r[k] <= {1'b0, s[14*k-21 +: 7], 1'b0, s[14*k-28 +: 7]};
        else if (clr_r)
          sh_r[k] <= 16'h0000;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_take;
    s_req |=> s_ans;
  endproperty
  property p_idle;
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_hold;
    !(avs_read || avs_write) && avs_waitrequest |=> $stable(avs_readdata);
  endproperty
  property p_rst;
    $fell(sys_rst) |-> avs_waitrequest && avs_readdata == 32'h0;
  endproperty
  property p_map;
    avs_read && !avs_waitrequest && amp |-> avs_readdata == {16'h0000, exp_r};
  endproperty
  property p_rsvd;
    avs_read && !avs_waitrequest && amp |-> !avs_readdata[15] && !avs_readdata[7];
  endproperty
  property p_unmap;
    avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  property p_wr0;
    avs_write && !avs_waitrequest |=> avs_readdata == 32'h0;
  endproperty

  a_take: assert property (p_take) else $error("wait not one cycle");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_rst: assert property (p_rst) else $error("bad reset state");
  a_map: assert property (p_map) else $error("bad field map");
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  a_unmap: assert property (p_unmap) else $error("misaligned read not zero");
  a_wr0: assert property (p_wr0) else $error("write left read data");
endmodule : cra_regs_monitor

bind cra_regs_top cra_regs_monitor mon_u (.*);

// >>> sim/cra_regs_top_bench.sv
// Self-checking bench for the amplitude register bank
`timescale 1ns/10ps
module cra_regs_top_bench
  import cra_pkg::*;
;
  logic              clk_sys;
  logic              sys_rst;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [BE_W-1:0]   avs_byteenable;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              meas_done;
  logic [AMP_W-1:0]  amp_v [12];
  logic [AMP_W-1:0]  cap_v [12];
  int                num_errors;
  int                cmp_count;

  cra_regs_top dut_u (
    .clk_sys               (clk_sys),
    .sys_rst               (sys_rst),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_byteenable        (avs_byteenable),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .chan_a_peak1_strength (amp_v[0]),
    .chan_a_peak2_strength (amp_v[1]),
    .chan_a_peak3_strength (amp_v[2]),
    .chan_a_peak4_strength (amp_v[3]),
    .chan_a_peak5_strength (amp_v[4]),
    .chan_b_peak1_strength (amp_v[5]),
    .chan_b_peak2_strength (amp_v[6]),
    .chan_b_peak3_strength (amp_v[7]),
    .chan_b_peak4_strength (amp_v[8]),
    .chan_b_peak5_strength (amp_v[9]),
    .chan_c_peak1_strength (amp_v[10]),
    .chan_c_peak2_strength (amp_v[11]),
    .meas_done             (meas_done)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("Compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    avs_address <= adr;
    avs_writedata <= wd;
    avs_read <= !wr;
    avs_write <= wr;
    do
    begin
      @(posedge clk_sys);
    end
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 32'h0, d);
    check(d, exp);
  endtask : rd_chk

  task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    bus(1'b1, adr, wd, d);
  endtask : wr

  task automatic read_all;
    for (int k = 0; k < 6; k++)
      rd_chk(12'(12'h668 + 4 * k), {17'h0, cap_v[2*k+1], 1'b0, cap_v[2*k]});
  endtask : read_all

  // Inputs move away after the strobe so a transparent register shows up
  task automatic capture(input logic [6:0] base, input logic frozen);
    for (int i = 0; i < 12; i++)
      amp_v[i] <= base + 7'(9 * i);
    meas_done <= 1'b1;
    @(posedge clk_sys);
    meas_done <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      if (!frozen)
        cap_v[i] = amp_v[i];
      amp_v[i] <= ~amp_v[i];
    end
    @(posedge clk_sys);
  endtask : capture

  task automatic do_reset(input int n);
    sys_rst <= 1'b1;
    repeat (n) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 12; i++)
      cap_v[i] = 7'h00;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scn_map;
    capture(7'h7f, 1'b0);
    read_all();
    capture(7'h15, 1'b0);
    read_all();
  endtask : scn_map

  task automatic scn_read_only;
    for (int k = 0; k < 6; k++)
      wr(12'(12'h668 + 4 * k), 32'hffff_ffff);
    wr(12'h680, 32'hffff_ffff);
    rd_chk(12'h669, 32'h0);
    read_all();
  endtask : scn_read_only

  task automatic scn_freeze_clear;
    wr(12'h6c0, 32'h1);
    capture(7'h33, 1'b1);
    read_all();
    rd_chk(12'h6c4, 32'h0000_0207);
    avs_byteenable <= 4'he;
    wr(12'h6c0, 32'h0);
    avs_byteenable <= 4'hf;
    rd_chk(12'h6c0, 32'h0000_0001);
    wr(12'h6c0, 32'h2);
    for (int i = 0; i < 12; i++)
      cap_v[i] = 7'h00;
    read_all();
    rd_chk(12'h6c4, 32'h0000_0000);
  endtask : scn_freeze_clear

  task automatic scn_rereset;
    capture(7'h44, 1'b0);
    do_reset(3);
    read_all();
  endtask : scn_rereset

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end

  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    meas_done = 1'b0;
    for (int i = 0; i < 12; i++)
      amp_v[i] = 7'h00;
    do_reset(12);
    read_all();
    scn_map();
    scn_read_only();
    scn_freeze_clear();
    scn_rereset();
    conclude();
  end
endmodule : cra_regs_top_bench
